// file: design/cpu_control_instr_exec.sv
// Executor for register load/store, context return and external-control instructions
// Notes on behaviour
// - Loading the frame base from the immediate word changes no flag and costs 10 clocks and 2 accesses.
// - Loading the interrupt mask copies immediate bits 0-3 into flag bits 0-3.
// - Storing flags or frame base writes that word to the chosen register, keeps flags, costs 8 clocks.
// - Context return loads flags from register 15, program counter from 14 and frame base from 13.
// - Each external-control instruction puts a three-bit code on the top address lines and pulses the strobe.
// - Idle halts execution until an interrupt, a restore-load request or reset, showing low-high-low.
// - Mask clearing shows low-high-high and zeroes the mask; the user codes show high-high-low, high-low-high, high-high-high.
// - The cycle-done output goes low in the final clock of each instruction.
// - Duration is the clock count plus wait states times memory accesses.
// - Base counts assume register addressing; other modes add their extra clocks and accesses.
// - Divide with overflow takes 16 clocks, otherwise a variable count and 6 accesses.
// - Execute-remote costs the target's time plus its own, less 4 clocks and 1 access.
module cpu_control_instr_exec #(
  parameter int CYC_W = cpu_exec_pkg::CYC_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [15:0] instr_word,
  input wire logic [1:0] op_class,
  input wire logic [15:0] immediate_operand,
  input wire logic [15:0] ctx_wr13,
  input wire logic [15:0] ctx_wr14,
  input wire logic [15:0] ctx_wr15,
  input wire logic [8:0] gen_cycles,
  input wire logic [3:0] gen_accesses,
  input wire logic [8:0] addr_extra_cycles,
  input wire logic [3:0] addr_extra_accesses,
  input wire logic [3:0] wait_states,
  input wire logic div_overflow,
  input wire logic [8:0] div_cycles,
  input wire logic [8:0] remote_cycles,
  input wire logic [3:0] remote_accesses,
  input wire logic irq_pin,
  input wire logic load_pin,
  output logic [15:0] frame_base,
  output logic [15:0] flag_word,
  output logic [15:0] prog_counter,
  output logic store_valid,
  output logic [3:0] store_reg,
  output logic [15:0] store_data,
  output logic [2:0] ext_code,
  output logic bit_io_strobe,
  output logic micro_cycle_done_n,
  output logic halted,
  output logic busy
);

  if (CYC_W != cpu_exec_pkg::CYC_W) begin : g_chk
    $error("cpu_control_instr_exec: CYC_W must match the cost path width");
  end

  typedef enum logic [2:0] {
    S_READY = 3'b001,
    S_EXEC = 3'b010,
    S_HALT = 3'b100
  } state_type;

  state_type state_r;
  state_type state_nxt;
  cpu_exec_pkg::kind_type kind_r;
  cpu_exec_pkg::kind_type kind_in;
  cost_if cif ();

  logic [10:0] op_hi;
  logic [15:0] wp_r, flags_r, pc_r, imm_r, wr13_r, wr14_r, wr15_r;
  logic [3:0] sel_r;
  logic [2:0] code_r, code_in;
  logic strobe_r, store_valid_r;
  logic [3:0] store_reg_r;
  logic [15:0] store_data_r;
  logic [1:0] irq_sync_r, load_sync_r;
  logic wake;
  logic accept, finish, is_ext_in;
  logic [8:0] base_c, cost_c;
  logic [3:0] base_m, cost_m;
  logic [8:0] tgt_c, div_c;
  logic [3:0] div_m;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign op_hi = instr_word[cpu_exec_pkg::OP_HI_LSB +: cpu_exec_pkg::OP_HI_W];
  assign kind_in =
    (op_class == cpu_exec_pkg::CLASS_DIVIDE) ? cpu_exec_pkg::K_DIV :
    (op_class == cpu_exec_pkg::CLASS_REMOTE) ? cpu_exec_pkg::K_REMOTE :
    (op_hi == cpu_exec_pkg::OP_LOAD_FRAME_BASE_IMM) ? cpu_exec_pkg::K_LOAD_BASE :
    (op_hi == cpu_exec_pkg::OP_LOAD_IRQ_MASK_IMM) ? cpu_exec_pkg::K_LOAD_MASK :
    (op_hi == cpu_exec_pkg::OP_STORE_FLAGS) ? cpu_exec_pkg::K_STORE_FLAGS :
    (op_hi == cpu_exec_pkg::OP_STORE_FRAME_BASE) ? cpu_exec_pkg::K_STORE_BASE :
    (op_hi == cpu_exec_pkg::OP_RETURN_FROM_CONTEXT) ? cpu_exec_pkg::K_RETURN :
    (op_hi == cpu_exec_pkg::OP_IDLE) ? cpu_exec_pkg::K_IDLE :
    (op_hi == cpu_exec_pkg::OP_CLEAR_MASK_EXT) ? cpu_exec_pkg::K_CLEAR_MASK :
    (op_hi == cpu_exec_pkg::OP_USER_EXT_CODE_A || op_hi == cpu_exec_pkg::OP_USER_EXT_CODE_B ||
     op_hi == cpu_exec_pkg::OP_USER_EXT_CODE_C) ? cpu_exec_pkg::K_USER : cpu_exec_pkg::K_OTHER;

  // ------------------------------------------------------------
  // Address line codes
  // ------------------------------------------------------------
  assign code_in =
    (op_class != cpu_exec_pkg::CLASS_DECODE) ? cpu_exec_pkg::CODE_NONE :
    (op_hi == cpu_exec_pkg::OP_IDLE) ? cpu_exec_pkg::CODE_IDLE :
    (op_hi == cpu_exec_pkg::OP_CLEAR_MASK_EXT) ? cpu_exec_pkg::CODE_CLEAR_MASK :
    (op_hi == cpu_exec_pkg::OP_USER_EXT_CODE_A) ? cpu_exec_pkg::CODE_USER_A :
    (op_hi == cpu_exec_pkg::OP_USER_EXT_CODE_B) ? cpu_exec_pkg::CODE_USER_B :
    (op_hi == cpu_exec_pkg::OP_USER_EXT_CODE_C) ? cpu_exec_pkg::CODE_USER_C : cpu_exec_pkg::CODE_NONE;
  assign is_ext_in = (code_in != cpu_exec_pkg::CODE_NONE);

  // ------------------------------------------------------------
  // Cost selection
  // ------------------------------------------------------------
  assign div_c = div_overflow ? cpu_exec_pkg::C_DIV_OVF : div_cycles;
  assign div_m = div_overflow ? cpu_exec_pkg::M_DIV_OVF : cpu_exec_pkg::M_DIV;
  // Own overhead less the credit; both figures kept so either can be retuned
  assign tgt_c = remote_cycles + cpu_exec_pkg::C_REMOTE_OWN - cpu_exec_pkg::C_REMOTE_CREDIT;
  assign base_c =
    (kind_in == cpu_exec_pkg::K_LOAD_BASE) ? cpu_exec_pkg::C_LOAD_BASE :
    (kind_in == cpu_exec_pkg::K_LOAD_MASK) ? cpu_exec_pkg::C_LOAD_MASK :
    (kind_in == cpu_exec_pkg::K_STORE_FLAGS ||
     kind_in == cpu_exec_pkg::K_STORE_BASE) ? cpu_exec_pkg::C_STORE :
    (kind_in == cpu_exec_pkg::K_RETURN) ? cpu_exec_pkg::C_RETURN :
    (is_ext_in) ? cpu_exec_pkg::C_EXT :
    (kind_in == cpu_exec_pkg::K_DIV) ? div_c :
    (kind_in == cpu_exec_pkg::K_REMOTE) ? tgt_c : gen_cycles;
  assign base_m =
    (kind_in == cpu_exec_pkg::K_LOAD_BASE) ? cpu_exec_pkg::M_LOAD_BASE :
    (kind_in == cpu_exec_pkg::K_LOAD_MASK) ? cpu_exec_pkg::M_LOAD_MASK :
    (kind_in == cpu_exec_pkg::K_STORE_FLAGS ||
     kind_in == cpu_exec_pkg::K_STORE_BASE) ? cpu_exec_pkg::M_STORE :
    (kind_in == cpu_exec_pkg::K_RETURN) ? cpu_exec_pkg::M_RETURN :
    (is_ext_in) ? cpu_exec_pkg::M_EXT :
    (kind_in == cpu_exec_pkg::K_DIV) ? div_m :
    (kind_in == cpu_exec_pkg::K_REMOTE) ?
      remote_accesses + cpu_exec_pkg::M_REMOTE_OWN - cpu_exec_pkg::M_REMOTE_CREDIT : gen_accesses;
  assign cost_c = base_c + addr_extra_cycles;
  assign cost_m = base_m + addr_extra_accesses;

  assign accept = (state_r == S_READY) && instr_valid;
  assign finish = (state_r == S_EXEC) && cif.last;
  assign wake = irq_sync_r[1] || load_sync_r[1];
  assign cif.load = accept;
  assign cif.cycles = cost_c;
  assign cif.accesses = cost_m;
  assign cif.waits = wait_states;

  cycle_counter #(.TOT_W(cpu_exec_pkg::CYC_W + cpu_exec_pkg::WAIT_W)) u_count (
    .clk(clk),
    .srst(srst),
    .cif(cif)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    case (state_r)
      S_READY: state_nxt = accept ? S_EXEC : S_READY;
      S_EXEC: state_nxt = !finish ? S_EXEC : (kind_r == cpu_exec_pkg::K_IDLE) ? S_HALT : S_READY;
      S_HALT: state_nxt = wake ? S_READY : S_HALT;
      default: state_nxt = S_READY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= S_READY;
      irq_sync_r <= 2'h0;
      load_sync_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      irq_sync_r <= {irq_sync_r[0], irq_pin};
      load_sync_r <= {load_sync_r[0], load_pin};
    end
  end

  // Operands captured at accept so callers need not hold them
  always_ff @(posedge clk) begin
    if (srst) begin
      kind_r <= cpu_exec_pkg::K_OTHER;
      imm_r <= cpu_exec_pkg::RST_WORD;
      wr13_r <= cpu_exec_pkg::RST_WORD;
      wr14_r <= cpu_exec_pkg::RST_WORD;
      wr15_r <= cpu_exec_pkg::RST_WORD;
      sel_r <= 4'h0;
    end else if (accept) begin
      kind_r <= kind_in;
      imm_r <= immediate_operand;
      wr13_r <= ctx_wr13;
      wr14_r <= ctx_wr14;
      wr15_r <= ctx_wr15;
      sel_r <= instr_word[cpu_exec_pkg::REG_SEL_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // External control code and strobe
  // ------------------------------------------------------------
  // Code is registered on the same edge as the strobe so it is valid for the whole pulse and held after it
  always_ff @(posedge clk) begin
    if (srst) begin
      code_r <= cpu_exec_pkg::CODE_NONE;
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= accept && is_ext_in;
      if (accept) begin
        code_r <= code_in;
      end else if ((finish && kind_r != cpu_exec_pkg::K_IDLE) || (state_r == S_HALT && wake)) begin
        code_r <= cpu_exec_pkg::CODE_NONE;
      end
    end
  end

  // ------------------------------------------------------------
  // Internal registers, updated in the final clock
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r <= cpu_exec_pkg::RST_WORD;
      flags_r <= cpu_exec_pkg::RST_WORD;
      pc_r <= cpu_exec_pkg::RST_WORD;
    end else if (finish) begin
      case (kind_r)
        cpu_exec_pkg::K_LOAD_BASE: wp_r <= imm_r;
        cpu_exec_pkg::K_LOAD_MASK: flags_r[cpu_exec_pkg::MASK_LSB +: cpu_exec_pkg::MASK_W] <=
          imm_r[cpu_exec_pkg::MASK_LSB +: cpu_exec_pkg::MASK_W];
        cpu_exec_pkg::K_CLEAR_MASK: flags_r[cpu_exec_pkg::MASK_LSB +: cpu_exec_pkg::MASK_W] <= '0;
        cpu_exec_pkg::K_RETURN: begin
          flags_r <= wr15_r;
          pc_r <= wr14_r;
          wp_r <= wr13_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      store_valid_r <= 1'b0;
      store_reg_r <= 4'h0;
      store_data_r <= cpu_exec_pkg::RST_WORD;
    end else begin
      store_valid_r <= finish &&
        (kind_r == cpu_exec_pkg::K_STORE_FLAGS || kind_r == cpu_exec_pkg::K_STORE_BASE);
      if (finish) begin
        store_reg_r <= sel_r;
        store_data_r <= (kind_r == cpu_exec_pkg::K_STORE_FLAGS) ? flags_r : wp_r;
      end
    end
  end

  assign instr_ready = (state_r == S_READY);
  assign frame_base = wp_r;
  assign flag_word = flags_r;
  assign prog_counter = pc_r;
  assign store_valid = store_valid_r;
  assign store_reg = store_reg_r;
  assign store_data = store_data_r;
  assign ext_code = code_r;
  assign bit_io_strobe = strobe_r;
  assign micro_cycle_done_n = !cif.last;
  assign halted = (state_r == S_HALT);
  assign busy = (state_r == S_EXEC);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [12:0] len_r;
  logic [12:0] want_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      len_r <= 13'h0000;
      want_r <= 13'h0000;
    end else if (accept) begin
      len_r <= 13'h0001;
      want_r <= 13'(cost_c) + 13'(wait_states) * 13'(cost_m);
    end else if (busy) begin
      len_r <= len_r + 13'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_BASE_LOAD: assert property (finish && kind_r == cpu_exec_pkg::K_LOAD_BASE |=>
    wp_r == $past(imm_r) && $stable(flags_r)) else $error("frame base not loaded");
  AST_BASE_COST: assert property (accept && kind_in == cpu_exec_pkg::K_LOAD_BASE && wait_states == 4'h0 &&
    addr_extra_cycles == 9'h000 |=> busy [*8] ##1 busy ##1 busy ##1 !busy) else $error("frame base load length");
  AST_MASK_LOAD: assert property (finish && kind_r == cpu_exec_pkg::K_LOAD_MASK |=>
    flags_r[3:0] == $past(imm_r[3:0]) && flags_r[15:4] == $past(flags_r[15:4])) else $error("mask load wrong");
  AST_STORE: assert property (finish && kind_r == cpu_exec_pkg::K_STORE_FLAGS |=>
    store_valid && store_data == flags_r && $stable(flags_r)) else $error("flag store wrong");
  AST_CTX_RETURN: assert property (finish && kind_r == cpu_exec_pkg::K_RETURN |=>
    flags_r == $past(wr15_r) && pc_r == $past(wr14_r) && wp_r == $past(wr13_r)) else $error("context return wrong");
  AST_EXT_STROBE: assert property (accept && is_ext_in |=> bit_io_strobe && ext_code == $past(code_in))
    else $error("external code or strobe missing");
  AST_IDLE_HALT: assert property (halted && !wake |=> halted && ext_code == cpu_exec_pkg::CODE_IDLE
    && !instr_ready) else $error("idle halt broken");
  AST_MASK_CLEAR: assert property (finish && kind_r == cpu_exec_pkg::K_CLEAR_MASK |=> flags_r[3:0] == 4'h0)
    else $error("mask not cleared");
  AST_DONE_LAST: assert property (busy && !micro_cycle_done_n |=> !busy) else $error("done not in last clock");
  AST_DURATION: assert property (finish |-> len_r == want_r) else $error("duration mismatch");
  AST_DIV_OVF: assert property (accept && kind_in == cpu_exec_pkg::K_DIV && div_overflow &&
    addr_extra_cycles == 9'h000 && wait_states == 4'h0 |=> ##15 !micro_cycle_done_n) else $error("divide length");
  AST_STROBE_PULSE: assert property (bit_io_strobe |=> !bit_io_strobe && $stable(ext_code))
    else $error("strobe not one clock");

  CVR_IDLE_WAKE: cover property (halted ##1 wake ##1 instr_ready);
  CVR_CTX_RETURN: cover property (finish && kind_r == cpu_exec_pkg::K_RETURN);
  CVR_USER_STROBE: cover property (bit_io_strobe && ext_code == cpu_exec_pkg::CODE_USER_C);
  CVR_WAITED: cover property (accept && wait_states != 4'h0);

endmodule

// file: shared/cpu_exec_pkg.sv
// Package: opcodes, address-line codes, cycle and access costs for the control-instruction executor
package cpu_exec_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int CYC_W = 9;
  localparam int ACC_W = 4;
  localparam int WAIT_W = 4;
  localparam int OP_HI_W = 11;
  localparam int OP_HI_LSB = 5;
  localparam int MASK_W = 4;
  localparam int MASK_LSB = 0;
  localparam int REG_SEL_W = 4;

  // ------------------------------------------------------------
  // Opcodes, upper eleven bits of the instruction word
  // ------------------------------------------------------------
  localparam logic [10:0] OP_LOAD_FRAME_BASE_IMM = 11'h017;
  localparam logic [10:0] OP_LOAD_IRQ_MASK_IMM = 11'h018;
  localparam logic [10:0] OP_STORE_FLAGS = 11'h016;
  localparam logic [10:0] OP_STORE_FRAME_BASE = 11'h015;
  localparam logic [10:0] OP_RETURN_FROM_CONTEXT = 11'h01C;
  localparam logic [10:0] OP_IDLE = 11'h01A;
  localparam logic [10:0] OP_CLEAR_MASK_EXT = 11'h01B;
  localparam logic [10:0] OP_USER_EXT_CODE_A = 11'h01E;
  localparam logic [10:0] OP_USER_EXT_CODE_B = 11'h01D;
  localparam logic [10:0] OP_USER_EXT_CODE_C = 11'h01F;

  // ------------------------------------------------------------
  // Top address line codes, bit 2 is the most significant line
  // ------------------------------------------------------------
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_IDLE = 3'h2;
  localparam logic [2:0] CODE_CLEAR_MASK = 3'h3;
  localparam logic [2:0] CODE_USER_A = 3'h6;
  localparam logic [2:0] CODE_USER_B = 3'h5;
  localparam logic [2:0] CODE_USER_C = 3'h7;

  // ------------------------------------------------------------
  // Instruction classes presented with the word
  // ------------------------------------------------------------
  localparam logic [1:0] CLASS_DECODE = 2'h0;
  localparam logic [1:0] CLASS_DIVIDE = 2'h1;
  localparam logic [1:0] CLASS_REMOTE = 2'h2;

  typedef enum logic [3:0] {
    K_OTHER = 4'h0, K_LOAD_BASE = 4'h1, K_LOAD_MASK = 4'h2, K_STORE_FLAGS = 4'h3, K_STORE_BASE = 4'h4,
    K_RETURN = 4'h5, K_IDLE = 4'h6, K_CLEAR_MASK = 4'h7, K_USER = 4'h8, K_DIV = 4'h9, K_REMOTE = 4'hA
  } kind_type;

  // ------------------------------------------------------------
  // Base costs with workspace register addressing
  // ------------------------------------------------------------
  localparam logic [8:0] C_LOAD_BASE = 9'h00A;
  localparam logic [3:0] M_LOAD_BASE = 4'h2;
  localparam logic [8:0] C_LOAD_MASK = 9'h00E;
  localparam logic [3:0] M_LOAD_MASK = 4'h2;
  localparam logic [8:0] C_STORE = 9'h008;
  localparam logic [3:0] M_STORE = 4'h2;
  localparam logic [8:0] C_RETURN = 9'h00E;
  localparam logic [3:0] M_RETURN = 4'h4;
  localparam logic [8:0] C_EXT = 9'h00C;
  localparam logic [3:0] M_EXT = 4'h1;
  localparam logic [8:0] C_DIV_OVF = 9'h010;
  localparam logic [3:0] M_DIV_OVF = 4'h3;
  localparam logic [3:0] M_DIV = 4'h6;
  localparam logic [8:0] C_REMOTE_OWN = 9'h004;
  localparam logic [3:0] M_REMOTE_OWN = 4'h1;
  localparam logic [8:0] C_REMOTE_CREDIT = 9'h004;
  localparam logic [3:0] M_REMOTE_CREDIT = 4'h1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;

endpackage

// file: shared/cost_if.sv
// Interface: cost load and progress between the executor and its cycle counter
interface cost_if;
  logic load;
  logic [8:0] cycles;
  logic [3:0] accesses;
  logic [3:0] waits;
  logic busy;
  logic last;
  modport ctl (output load, output cycles, output accesses, output waits, input busy, input last);
  modport cnt (input load, input cycles, input accesses, input waits, output busy, output last);
endinterface

// file: design/cycle_counter.sv
// Instruction duration counter: counts C plus wait states times accesses
module cycle_counter #(
  parameter int TOT_W = 13
) (
  input wire logic clk,
  input wire logic srst,
  cost_if.cnt cif
);

  logic [TOT_W-1:0] total;
  logic [TOT_W-1:0] cnt_r;
  logic busy_r;
  logic last_r;

  if (TOT_W < cpu_exec_pkg::CYC_W + cpu_exec_pkg::WAIT_W) begin : g_chk
    $error("cycle_counter: TOT_W too narrow");
  end

  // ------------------------------------------------------------
  // Duration in clocks
  // ------------------------------------------------------------
  assign total = TOT_W'(cif.cycles) + TOT_W'(cif.waits) * TOT_W'(cif.accesses);
  assign cif.busy = busy_r;
  assign cif.last = last_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      last_r <= 1'b0;
    end else if (cif.load) begin
      cnt_r <= total;
      busy_r <= 1'b1;
      last_r <= (total == TOT_W'(1));
    end else if (busy_r) begin
      cnt_r <= cnt_r - TOT_W'(1);
      busy_r <= !last_r;
      last_r <= (cnt_r == TOT_W'(2));
    end
  end

endmodule

// file: verification/ext_ctl_model.sv
// Far-side control logic model that decodes the address-line code at each strobe
module ext_ctl_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] ext_code,
  input wire logic bit_io_strobe,
  output logic [2:0] last_code,
  output logic [7:0] strobe_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Code capture
  // ----------------------------------------
  // Sampled on the strobe edge only, as real decode logic would do
  always_ff @(posedge clk) begin
    if (srst) begin
      last_code <= 3'h0;
      strobe_cnt <= 8'h00;
    end else if (bit_io_strobe) begin
      last_code <= ext_code;
      strobe_cnt <= strobe_cnt + 8'h01;
    end
  end
endmodule

// file: verification/cpu_control_instr_exec_bench.sv
// Self-checking bench for the control-instruction executor
module cpu_control_instr_exec_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, instr_valid, instr_ready, div_overflow, irq_pin, load_pin;
  logic [15:0] instr_word, immediate_operand, ctx_wr13, ctx_wr14, ctx_wr15;
  logic [1:0] op_class;
  logic [8:0] gen_cycles, addr_extra_cycles, div_cycles, remote_cycles;
  logic [3:0] gen_accesses, addr_extra_accesses, wait_states, remote_accesses, store_reg;
  logic [15:0] frame_base, flag_word, prog_counter, store_data;
  logic store_valid, bit_io_strobe, micro_cycle_done_n, halted, busy;
  logic [2:0] ext_code, last_code;
  logic [7:0] strobe_cnt;
  int mismatches, compares, k, g;
  logic [10:0] ext_ops [0:3] = '{cpu_exec_pkg::OP_CLEAR_MASK_EXT, cpu_exec_pkg::OP_USER_EXT_CODE_A,
    cpu_exec_pkg::OP_USER_EXT_CODE_B, cpu_exec_pkg::OP_USER_EXT_CODE_C};
  logic [2:0] ext_codes [0:3] = '{cpu_exec_pkg::CODE_CLEAR_MASK, cpu_exec_pkg::CODE_USER_A,
    cpu_exec_pkg::CODE_USER_B, cpu_exec_pkg::CODE_USER_C};

  cpu_control_instr_exec u_cpu_control_instr_exec (.clk, .srst, .instr_valid, .instr_ready, .instr_word,
    .op_class, .immediate_operand, .ctx_wr13, .ctx_wr14, .ctx_wr15, .gen_cycles, .gen_accesses,
    .addr_extra_cycles, .addr_extra_accesses, .wait_states, .div_overflow, .div_cycles, .remote_cycles,
    .remote_accesses, .irq_pin, .load_pin, .frame_base, .flag_word, .prog_counter, .store_valid,
    .store_reg, .store_data, .ext_code, .bit_io_strobe, .micro_cycle_done_n, .halted, .busy);
  ext_ctl_model u_ext_ctl_model (.clk, .srst, .ext_code, .bit_io_strobe, .last_code, .strobe_cnt);

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  // Wide enough for the packed multi-field compares below, so no field is cut off
  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // One instruction: offer, accept, measure busy span, done point and strobe
  // ----------------------------------------
  task automatic run(input logic [10:0] op, input logic [4:0] lo, input logic [1:0] cls, input int n_exp,
    input logic [2:0] code);
    int n, nd, nl, ns, t;
    logic [2:0] cs, cl;
    n = 0;
    nd = 0;
    nl = 0;
    ns = 0;
    cs = 3'h0;
    cl = 3'h0;
    instr_word = {op, lo};
    op_class = cls;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    for (t = 0; t < 300 && busy === 1'b1; t++) begin
      n++;
      if (micro_cycle_done_n === 1'b0) begin
        nd = n;
        nl++;
      end
      if (bit_io_strobe === 1'b1) begin
        ns++;
        cs = ext_code;
      end
      cl = ext_code;
      @(negedge clk);
    end
    if (t == 300) begin
      mismatches++;
      complete_run();
    end
    check("busy cycles", 16'(n_exp), 16'(n));
    check("done cycle", 16'(n_exp), 16'(nd));
    check("done count", 16'h0001, 16'(nl));
    check("strobes", {15'h0, code != 3'h0}, 16'(ns));
    check("code at strobe", {13'h0, code}, {13'h0, cs});
    check("code at end", {13'h0, code}, {13'h0, cl});
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {srst, instr_valid, div_overflow, irq_pin, load_pin} = 5'h10;
    {instr_word, immediate_operand, ctx_wr13, ctx_wr14, ctx_wr15} = '0;
    op_class = 2'h0;
    {gen_cycles, addr_extra_cycles, div_cycles, remote_cycles} = '0;
    {gen_accesses, addr_extra_accesses, wait_states, remote_accesses} = '0;
    mismatches = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    check("ready after reset", 16'h0001, {15'h0, instr_ready});
    check("done_n after reset", 16'h0001, {15'h0, micro_cycle_done_n});
    immediate_operand = 16'hA5A4;
    run(cpu_exec_pkg::OP_LOAD_FRAME_BASE_IMM, 5'h00, cpu_exec_pkg::CLASS_DECODE, 10, 3'h0);
    check("frame base", 16'hA5A4, frame_base);
    check("flags kept", 16'h0000, flag_word);
    immediate_operand = 16'h123B;
    wait_states = 4'h2;
    run(cpu_exec_pkg::OP_LOAD_IRQ_MASK_IMM, 5'h00, cpu_exec_pkg::CLASS_DECODE, 18, 3'h0);
    check("mask", 16'h000B, flag_word);
    {wait_states, addr_extra_cycles, addr_extra_accesses} = {4'h1, 9'h004, 4'h1};
    run(cpu_exec_pkg::OP_STORE_FLAGS, 5'h05, cpu_exec_pkg::CLASS_DECODE, 15, 3'h0);
    check("store flags", {1'b1, 3'h0, 4'h5, 16'h000B}, {store_valid, 3'h0, store_reg, store_data});
    {wait_states, addr_extra_cycles, addr_extra_accesses} = '0;
    run(cpu_exec_pkg::OP_STORE_FRAME_BASE, 5'h09, cpu_exec_pkg::CLASS_DECODE, 8, 3'h0);
    check("store base", {1'b1, 3'h0, 4'h9, 16'hA5A4}, {store_valid, 3'h0, store_reg, store_data});
    check("flags after stores", 16'h000B, flag_word);
    {ctx_wr13, ctx_wr14, ctx_wr15, wait_states} = {16'h0F0E, 16'h1234, 16'hC3F5, 4'h1};
    run(cpu_exec_pkg::OP_RETURN_FROM_CONTEXT, 5'h00, cpu_exec_pkg::CLASS_DECODE, 18, 3'h0);
    check("ctx regs", {16'hC3F5, 16'h1234, 16'h0F0E}, {flag_word, prog_counter, frame_base});
    for (k = 0; k < 4; k++) begin
      run(ext_ops[k], 5'h00, cpu_exec_pkg::CLASS_DECODE, 13, ext_codes[k]);
      check("far side code", {13'h0, ext_codes[k]}, {13'h0, last_code});
      check("far side count", 16'(k + 1), {8'h0, strobe_cnt});
      check("code cleared", 16'h0000, {13'h0, ext_code});
    end
    check("mask cleared", 16'hC3F0, flag_word);
    for (k = 0; k < 2; k++) begin
      run(cpu_exec_pkg::OP_IDLE, 5'h00, cpu_exec_pkg::CLASS_DECODE, 13, cpu_exec_pkg::CODE_IDLE);
      instr_valid = 1'b1;
      repeat (3) @(negedge clk);
      check("idle holds", {15'h0, 1'b1, 13'h0, cpu_exec_pkg::CODE_IDLE}, {busy, halted, 13'h0, ext_code});
      instr_valid = 1'b0;
      if (k == 0) irq_pin = 1'b1;
      else load_pin = 1'b1;
      for (g = 0; g < 8 && halted !== 1'b0; g++) @(negedge clk);
      if (g == 8) begin
        mismatches++;
        complete_run();
      end
      check("wake", 16'h0001, {12'h0, ext_code, instr_ready});
      {irq_pin, load_pin} = 2'h0;
    end
    {div_overflow, wait_states} = {1'b1, 4'h1};
    run(11'h000, 5'h00, cpu_exec_pkg::CLASS_DIVIDE, 19, 3'h0);
    {div_overflow, div_cycles, wait_states} = {1'b0, 9'd92, 4'h1};
    run(11'h000, 5'h00, cpu_exec_pkg::CLASS_DIVIDE, 98, 3'h0);
    {remote_cycles, remote_accesses} = {9'd20, 4'h3};
    run(11'h000, 5'h00, cpu_exec_pkg::CLASS_REMOTE, 23, 3'h0);
    {gen_cycles, gen_accesses} = {9'd7, 4'h2};
    run(11'h000, 5'h00, cpu_exec_pkg::CLASS_DECODE, 9, 3'h0);
    complete_run();
  end
endmodule
